/* spi_cmd_regs.vh */
// Constants for the SPI command decoder: command bytes with parity,
// frame geometry, lock keys, status byte layout and reset values.
// Included by spi_command_decode.v only.
`ifndef SPI_CMD_REGS_VH
`define SPI_CMD_REGS_VH

// Frame geometry.
`define FRAME_BITS 5'h10
`define BYTE_BITS 5'h08
`define CNT_MAX 5'h11

// Lock keys and the only valid sleep data.
`define LOCK_KEY 8'hAA
`define UNLOCK_KEY 8'h55
`define SLEEP_DATA 8'h00

// Status byte fixed pattern and flag positions.
`define STAT_FIXED 4'hA
`define STAT_WR_BIT 3
`define STAT_ERR_BIT 0

// Control commands.
`define CMD_LOCK 8'hBD
`define CMD_UNLOCK 8'hBB
`define CMD_SLEEP 8'h7D

// Write commands.
`define CMD_WR_CFG1 8'hB7
`define CMD_WR_CFG2 8'h95
`define CMD_WR_ERR_CFG 8'hDB
`define CMD_WR_ERR_STAT 8'hA9
`define CMD_WR_PWD_THR 8'h99
`define CMD_WR_CHECK 8'h93
`define CMD_WR_BIST 8'h9F
`define CMD_WR_WIN1 8'hED
`define CMD_WR_WIN2 8'h09
`define CMD_WR_DIAG_CFG 8'hCC
`define CMD_WR_DIAG_MUX 8'hC9

// Read commands.
`define CMD_RD_ID 8'h06
`define CMD_RD_REV 8'h0C
`define CMD_RD_CFG1 8'hAF
`define CMD_RD_CFG2 8'h48
`define CMD_RD_STAT1 8'h24
`define CMD_RD_STAT2 8'hC5
`define CMD_RD_STAT3 8'hA3
`define CMD_RD_STAT4 8'hA5
`define CMD_RD_STAT5 8'hC0
`define CMD_RD_ERR_CFG 8'h30
`define CMD_RD_ERR_STAT 8'hAA
`define CMD_RD_PWD_THR 8'h39
`define CMD_RD_CHECK 8'h44
`define CMD_RD_BIST 8'h3C
`define CMD_RD_WIN1 8'h2E
`define CMD_RD_WIN2 8'h05
`define CMD_RD_DIAG_CFG 8'hDD
`define CMD_RD_DIAG_MUX 8'hAC

// Initial register values.
`define RST_REG 8'h00
`define STATE_LSB 0
`define STATE_MSB 2

`endif

/* spi_command_decode.v */
// SPI slave command decoder with software write lock and diagnostic gating.
// Assumes SCLK, NCS and SDI come from an external master in another clock
// domain and are oversampled by clk; reset is the power-on reset event.
`timescale 1ns/1ps
`default_nettype none
`include "spi_cmd_regs.vh"

// Behaviour
// [R01] Command byte must have even parity.
// [R02] Command code bits 7:1, parity bit 0.
// [R03] Bad parity or code flagged next response.
// [R04] Lock command with AAh sets write lock.
// [R05] Unlock command with 55h clears lock.
// [R06] Config one written only diagnostic, unlocked.
// [R07] Config two written only diagnostic, unlocked.
// [R08] Sleep command ignores lock, needs 00h.
// [R09] Safety error config: diagnostic, unlocked only.
// [R10] Safety error status: diagnostic, unlocked only.
// [R11] Pulse threshold: diagnostic, unlocked only.
// [R12] Window one config: diagnostic, unlocked only.
// [R13] Window two config: diagnostic, unlocked only.
// [R14] Power-on reset loads all initial values.
// [R15] Self-test completion reinitializes listed registers.
// [R16] State field shows current state at reinit.
// [R17] Software masks reserved bits on reads.
// [R18] Reads return register; rejected writes change nothing.
module spi_command_decode #(
    parameter [7:0] DEVICE_ID = 8'h5A, // Arbitrary value.
    parameter [7:0] DEVICE_REV = 8'h11 // Arbitrary value.
) (
    // Clock and power-on reset.
    input wire clk,
    input wire reset,
    // SPI pins.
    input wire spiClk,
    input wire chipSelect_n,
    input wire serialIn,
    output reg serialOut,
    output reg serialOutEnable,
    // Device condition, same clock domain.
    input wire diagState,
    input wire [2:0] deviceState,
    input wire logicSelfTestDone,
    input wire [7:0] safetyStat1,
    input wire [7:0] safetyStat3,
    input wire [7:0] stat2Events,
    input wire [7:0] stat4Events,
    // Control outputs.
    output reg writeLocked,
    output reg transceiverSleep,
    output reg [7:0] configOne,
    output reg [7:0] configTwo,
    output reg [7:0] safetyErrCfg,
    output reg [7:0] safetyErrStat,
    output reg [7:0] pulseThreshold,
    output reg [7:0] safetyCheckCtrl,
    output reg [7:0] selfTestCtrl,
    output reg [7:0] windowOne,
    output reg [7:0] windowTwo,
    output reg [7:0] diagCfgCtrl,
    output reg [7:0] diagMuxSel
);

    reg [2:0] sclkSync;
    reg [2:0] csSync;
    reg [1:0] sdiSync;
    reg [4:0] bitCount;
    reg [15:0] rxShift;
    reg [7:0] txByte;
    reg [7:0] safetyStat2;
    reg [7:0] safetyStat4;
    reg [7:0] safetyStat5;
    reg prevError;
    reg prevWrite;

    // Edges are taken from the second and third stages only.
    wire sclkFall = sclkSync[2] & ~sclkSync[1];
    wire sclkRise = ~sclkSync[2] & sclkSync[1];
    wire csFall = csSync[2] & ~csSync[1];
    wire csRise = ~csSync[2] & csSync[1];
    wire csActive = ~csSync[1];
    wire [7:0] cmdByte = rxShift[15:8];
    wire [7:0] dataByte = rxShift[7:0];
    wire parityOk = ~^cmdByte; // [R01] [R02]
    wire [7:0] statusByte = {`STAT_FIXED, prevWrite, 2'b00, prevError};
    // Restricted writes need the diagnostic state and a clear lock.
    wire restrictedOk = diagState & ~writeLocked;

    reg [7:0] readData;

    // Decode on the command byte alone so read data is ready mid-frame.
    always @*
    begin
        readData = `RST_REG;
        case (rxShift[7:0]) // [R18]
            `CMD_RD_ID: readData = DEVICE_ID;
            `CMD_RD_REV: readData = DEVICE_REV;
            `CMD_RD_CFG1: readData = configOne;
            `CMD_RD_CFG2: readData = configTwo;
            `CMD_RD_STAT1: readData = safetyStat1;
            `CMD_RD_STAT2: readData = safetyStat2;
            `CMD_RD_STAT3: readData = safetyStat3;
            `CMD_RD_STAT4: readData = safetyStat4;
            `CMD_RD_STAT5: readData = safetyStat5;
            `CMD_RD_ERR_CFG: readData = safetyErrCfg;
            `CMD_RD_ERR_STAT: readData = safetyErrStat;
            `CMD_RD_PWD_THR: readData = pulseThreshold;
            `CMD_RD_CHECK: readData = safetyCheckCtrl;
            `CMD_RD_BIST: readData = selfTestCtrl;
            `CMD_RD_WIN1: readData = windowOne;
            `CMD_RD_WIN2: readData = windowTwo;
            `CMD_RD_DIAG_CFG: readData = diagCfgCtrl;
            `CMD_RD_DIAG_MUX: readData = diagMuxSel;
            default: readData = `RST_REG;
        endcase
    end

    // Final decode at frame end checks the command byte against every read and write code.
    reg endKnown;
    reg endWrite;
    always @*
    begin
        endKnown = 1'b1;
        endWrite = 1'b0;
        case (cmdByte)
            `CMD_RD_ID, `CMD_RD_REV, `CMD_RD_CFG1, `CMD_RD_CFG2,
            `CMD_RD_STAT1, `CMD_RD_STAT2, `CMD_RD_STAT3, `CMD_RD_STAT4,
            `CMD_RD_STAT5, `CMD_RD_ERR_CFG, `CMD_RD_ERR_STAT,
            `CMD_RD_PWD_THR, `CMD_RD_CHECK, `CMD_RD_BIST, `CMD_RD_WIN1,
            `CMD_RD_WIN2, `CMD_RD_DIAG_CFG, `CMD_RD_DIAG_MUX: endWrite = 1'b0;
            `CMD_LOCK, `CMD_UNLOCK, `CMD_SLEEP, `CMD_WR_CFG1,
            `CMD_WR_CFG2, `CMD_WR_ERR_CFG, `CMD_WR_ERR_STAT,
            `CMD_WR_PWD_THR, `CMD_WR_CHECK, `CMD_WR_BIST,
            `CMD_WR_WIN1, `CMD_WR_WIN2, `CMD_WR_DIAG_CFG,
            `CMD_WR_DIAG_MUX: endWrite = 1'b1;
            default: endKnown = 1'b0; // [R03]
        endcase
    end

    wire frameOk = (bitCount == `FRAME_BITS) & parityOk & endKnown; // [R03]
    wire commit = csRise & frameOk & endWrite;

    // Pin synchronisers and frame shifting.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sclkSync <= 3'h0;
            csSync <= 3'h7;
            sdiSync <= 2'h0;
            bitCount <= 5'h00;
            rxShift <= 16'h0000;
            txByte <= `RST_REG;
            serialOut <= 1'b0;
            serialOutEnable <= 1'b0;
            prevError <= 1'b0;
            prevWrite <= 1'b0;
        end
        else
        begin
            sclkSync <= {sclkSync[1:0], spiClk};
            csSync <= {csSync[1:0], chipSelect_n};
            sdiSync <= {sdiSync[0], serialIn};
            serialOutEnable <= csActive;
            if (csFall)
            begin
                bitCount <= 5'h00;
                serialOut <= statusByte[7];
                // The first rise repeats bit 7, so the master sees it first.
                txByte <= statusByte;
            end
            else if (csActive && sclkFall)
            begin
                rxShift <= {rxShift[14:0], sdiSync[1]};
                if (bitCount != `CNT_MAX)
                    bitCount <= bitCount + 5'h01;
            end
            else if (csActive && sclkRise)
            begin
                if (bitCount == `BYTE_BITS)
                begin
                    // First data bit: the command byte is complete here.
                    serialOut <= readData[7]; // [R18]
                    txByte <= {readData[6:0], 1'b0};
                end
                else
                begin
                    serialOut <= txByte[7];
                    txByte <= {txByte[6:0], 1'b0};
                end
            end
            if (csRise)
            begin
                prevError <= ~frameOk; // [R03]
                prevWrite <= frameOk & endWrite;
            end
        end
    end

    // Register file; reset is the power-on event that loads every register.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            writeLocked <= 1'b0; // [R14]
            transceiverSleep <= 1'b0;
            configOne <= `RST_REG;
            configTwo <= `RST_REG;
            safetyErrCfg <= `RST_REG;
            safetyErrStat <= `RST_REG;
            pulseThreshold <= `RST_REG;
            safetyCheckCtrl <= `RST_REG;
            selfTestCtrl <= `RST_REG;
            windowOne <= `RST_REG;
            windowTwo <= `RST_REG;
            diagCfgCtrl <= `RST_REG;
            diagMuxSel <= `RST_REG;
            safetyStat2 <= `RST_REG;
            safetyStat4 <= `RST_REG;
            safetyStat5 <= `RST_REG;
        end
        else
        begin
            transceiverSleep <= 1'b0;
            // Sticky events are ORed in after reinit so a coincident set wins.
            if (logicSelfTestDone)
            begin
                safetyStat2 <= stat2Events; // [R15]
                safetyStat4 <= stat4Events; // [R15]
                safetyCheckCtrl <= `RST_REG; // [R15]
                diagCfgCtrl <= `RST_REG; // [R15]
                diagMuxSel <= `RST_REG; // [R15]
            end
            else
            begin
                safetyStat2 <= safetyStat2 | stat2Events;
                safetyStat4 <= safetyStat4 | stat4Events;
            end
            // The state field follows deviceState on every clock, not only at reinit.
            safetyStat5 <= {5'h00, deviceState}; // [R16]
            if (commit)
            begin
                // Rejected writes fall through every branch untouched.
                case (cmdByte) // [R18]
                    `CMD_LOCK:
                        if (dataByte == `LOCK_KEY)
                            writeLocked <= 1'b1; // [R04]
                    `CMD_UNLOCK:
                        if (dataByte == `UNLOCK_KEY)
                            writeLocked <= 1'b0; // [R05]
                    `CMD_SLEEP:
                        if (dataByte == `SLEEP_DATA)
                            transceiverSleep <= 1'b1; // [R08]
                    `CMD_WR_CFG1:
                        if (restrictedOk)
                            configOne <= dataByte; // [R06]
                    `CMD_WR_CFG2:
                        if (restrictedOk)
                            configTwo <= dataByte; // [R07]
                    `CMD_WR_ERR_CFG:
                        if (restrictedOk)
                            safetyErrCfg <= dataByte; // [R09]
                    `CMD_WR_ERR_STAT:
                        if (restrictedOk)
                            safetyErrStat <= dataByte; // [R10]
                    `CMD_WR_PWD_THR:
                        if (restrictedOk)
                            pulseThreshold <= dataByte; // [R11]
                    `CMD_WR_WIN1:
                        if (restrictedOk)
                            windowOne <= dataByte; // [R12]
                    `CMD_WR_WIN2:
                        if (restrictedOk)
                            windowTwo <= dataByte; // [R13]
                    `CMD_WR_BIST:
                        if (!writeLocked)
                            selfTestCtrl <= dataByte;
                    `CMD_WR_CHECK:
                        if (!logicSelfTestDone)
                            safetyCheckCtrl <= dataByte;
                    `CMD_WR_DIAG_CFG:
                        if (!logicSelfTestDone)
                            diagCfgCtrl <= dataByte;
                    `CMD_WR_DIAG_MUX:
                        if (!logicSelfTestDone)
                            diagMuxSel <= dataByte;
                    default:
                        writeLocked <= writeLocked;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* spi_master_model.sv */
// Master side of the command link: 16-bit frames, clock idle low.
// Assumes the slave samples on falling and drives on rising edges.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // Link pins.
    output logic spiClk,
    output logic chipSelect_n,
    output logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEnable
);
    initial
    begin
        spiClk = 1'b0;
        chipSelect_n = 1'b1;
        serialIn = 1'b1;
    end
    // One frame; bad flips the parity so a refusal can be provoked.
    task automatic xfer(input logic [6:0] code, input logic [7:0] data,
        input logic bad, output logic [15:0] rx);
        logic [15:0] tx;
        tx = {code, ^code ^ bad, data};
        chipSelect_n = 1'b0;
        #62.5;
        for (int i = 15; i >= 0; i--)
        begin
            spiClk = 1'b1;
            serialIn = tx[i];
            #62.5;
            spiClk = 1'b0;
            // An undriven line shows the inverse, so a late enable is seen.
            rx[i] = serialOutEnable ? serialOut : ~serialOut;
            #62.5;
        end
        chipSelect_n = 1'b1;
        // A released line must not keep looking like valid data.
        serialIn = ~serialIn;
        #800;
    endtask
endmodule
`default_nettype wire

/* spi_command_decode_props.sv */
// Port checker for the command decoder.
// Assumes one clock domain and the asynchronous power-on reset.
`timescale 1ns/1ps
`default_nettype none
module spi_command_decode_props (
    // Clock, reset and frame pins.
    input wire logic clk,
    input wire logic reset,
    input wire logic chipSelect_n,
    input wire logic serialOutEnable,
    // Device condition.
    input wire logic diagState,
    input wire logic logicSelfTestDone,
    // Controls and registers.
    input wire logic writeLocked,
    input wire logic transceiverSleep,
    input wire logic [7:0] configOne,
    input wire logic [7:0] configTwo,
    input wire logic [7:0] safetyErrCfg,
    input wire logic [7:0] windowOne,
    input wire logic [7:0] diagMuxSel,
    input wire logic [7:0] diagCfgCtrl,
    input wire logic [7:0] safetyCheckCtrl
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_cs_fall;
        $fell(chipSelect_n);
    endsequence
    sequence s_cs_rise;
        $rose(chipSelect_n);
    endsequence
    cfg_one_gate_a: assert property ($changed(configOne) |->
        $past(diagState) && !$past(writeLocked)) else $error("cfg1 gate");
    cfg_two_gate_a: assert property ($changed(configTwo) |->
        $past(diagState) && !$past(writeLocked)) else $error("cfg2 gate");
    err_cfg_gate_a: assert property ($changed(safetyErrCfg) |->
        $past(diagState) && !$past(writeLocked)) else $error("err gate");
    win_one_gate_a: assert property ($changed(windowOne) |->
        $past(diagState) && !$past(writeLocked)) else $error("win gate");
    sleep_pulse_a: assert property (transceiverSleep |=>
        !transceiverSleep) else $error("sleep pulse too long");
    sleep_idle_a: assert property (transceiverSleep |->
        chipSelect_n) else $error("sleep inside frame");
    reinit_clear_a: assert property (logicSelfTestDone |=>
        (diagMuxSel | diagCfgCtrl | safetyCheckCtrl) == 8'h00)
        else $error("reinit missed");
    sdo_enable_a: assert property (s_cs_fall |->
        ##[1:5] serialOutEnable) else $error("sdo not driven");
    sdo_release_a: assert property (s_cs_rise |->
        ##[1:5] !serialOutEnable) else $error("sdo not released");
endmodule
bind spi_command_decode spi_command_decode_props i_props (.clk, .reset,
    .chipSelect_n, .serialOutEnable, .diagState, .logicSelfTestDone,
    .writeLocked, .transceiverSleep, .configOne, .configTwo, .safetyErrCfg,
    .windowOne, .diagMuxSel, .diagCfgCtrl, .safetyCheckCtrl);
`default_nettype wire

/* spi_command_decode_bench.sv */
// Self-checking bench for the command decoder and its write lock.
// Assumes the master model drives the link pins.
`timescale 1ns/1ps
`default_nettype none
module spi_command_decode_bench;
    logic clk, reset, spiClk, chipSelect_n, serialIn, serialOut;
    logic serialOutEnable, diagState, logicSelfTestDone, writeLocked;
    logic transceiverSleep, sleepSeen;
    logic [2:0] deviceState;
    logic [7:0] safetyStat1, safetyStat3, stat2Events, stat4Events;
    logic [7:0] configOne, configTwo, safetyErrCfg, safetyErrStat;
    logic [7:0] pulseThreshold, safetyCheckCtrl, selfTestCtrl, windowOne;
    logic [7:0] windowTwo, diagCfgCtrl, diagMuxSel;
    logic [15:0] rx;
    int bad_count = 0;
    int tests_run = 0;
    spi_command_decode #(.DEVICE_ID(8'hC6), .DEVICE_REV(8'h4B))
        i_spi_command_decode (.clk, .reset, .spiClk, .chipSelect_n,
        .serialIn, .serialOut, .serialOutEnable, .diagState, .deviceState,
        .logicSelfTestDone, .safetyStat1, .safetyStat3, .stat2Events,
        .stat4Events, .writeLocked, .transceiverSleep, .configOne,
        .configTwo, .safetyErrCfg, .safetyErrStat, .pulseThreshold,
        .safetyCheckCtrl, .selfTestCtrl, .windowOne, .windowTwo,
        .diagCfgCtrl, .diagMuxSel);
    spi_master_model i_spi_master_model (.spiClk, .chipSelect_n,
        .serialIn, .serialOut, .serialOutEnable);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (transceiverSleep === 1'b1)
            sleepSeen <= 1'b1;
    task final_report;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task frame(input logic [6:0] code, input logic [7:0] data,
        input logic bad);
        i_spi_master_model.xfer(code, data, bad, rx);
        @(posedge clk) #1;
    endtask
    task t_reads;
        chk({writeLocked, transceiverSleep, serialOutEnable, 5'h00}, 8'h00);
        chk(configOne | configTwo | safetyErrCfg | windowTwo, 8'h00);
        frame(7'h03, 8'h00, 1'b0);
        chk(rx[15:8], 8'hA0);
        chk(rx[7:0], 8'hC6);
        frame(7'h06, 8'h00, 1'b0);
        chk(rx[7:0], 8'h4B);
        frame(7'h12, 8'h00, 1'b0);
        chk(rx[7:0], 8'h96);
        frame(7'h51, 8'h00, 1'b0);
        chk(rx[7:0], 8'h3C);
    endtask
    task t_writes;
        logic [6:0] wc [0:6];
        logic [6:0] rc [0:6];
        wc = '{7'h5B, 7'h4A, 7'h6D, 7'h54, 7'h4C, 7'h76, 7'h04};
        rc = '{7'h57, 7'h24, 7'h18, 7'h55, 7'h1C, 7'h17, 7'h02};
        for (int i = 0; i < 7; i++)
        begin
            diagState = 1'b0;
            frame(wc[i], 8'h30 + i[7:0], 1'b0);
            frame(rc[i], 8'h00, 1'b0);
            chk(rx[15:8], 8'hA8);
            chk(rx[7:0], 8'h00);
            diagState = 1'b1;
            frame(wc[i], 8'h30 + i[7:0], 1'b0);
            frame(rc[i], 8'h00, 1'b0);
            chk(rx[7:0], 8'h30 + i[7:0]);
        end
    endtask
    task t_lock;
        frame(7'h5E, 8'h55, 1'b0);
        chk({7'h00, writeLocked}, 8'h00);
        frame(7'h5E, 8'hAA, 1'b0);
        chk({7'h00, writeLocked}, 8'h01);
        frame(7'h4F, 8'h66, 1'b0);
        chk(selfTestCtrl, 8'h00);
        frame(7'h5B, 8'hC3, 1'b0);
        frame(7'h4A, 8'hC3, 1'b0);
        chk(configOne, 8'h30);
        chk(configTwo, 8'h31);
        sleepSeen = 1'b0;
        frame(7'h3E, 8'h01, 1'b0);
        chk({7'h00, sleepSeen}, 8'h00);
        frame(7'h3E, 8'h00, 1'b0);
        chk({7'h00, sleepSeen}, 8'h01);
        frame(7'h5D, 8'hAA, 1'b0);
        chk({7'h00, writeLocked}, 8'h01);
        frame(7'h5D, 8'h55, 1'b0);
        chk({7'h00, writeLocked}, 8'h00);
        frame(7'h5B, 8'hC3, 1'b0);
        chk(configOne, 8'hC3);
        frame(7'h4F, 8'h66, 1'b0);
        chk(selfTestCtrl, 8'h66);
    endtask
    task t_error;
        frame(7'h5B, 8'h11, 1'b1);
        frame(7'h7F, 8'h00, 1'b0);
        chk(rx[15:8], 8'hA1);
        chk(configOne, 8'hC3);
        frame(7'h57, 8'h00, 1'b0);
        chk(rx[15:8], 8'hA1);
        chk(rx[7:0], 8'hC3);
    endtask
    task t_reinit;
        frame(7'h64, 8'h5A, 1'b0);
        frame(7'h66, 8'hA5, 1'b0);
        frame(7'h49, 8'h3C, 1'b0);
        chk(diagMuxSel & diagCfgCtrl, 8'h00);
        chk(diagMuxSel | diagCfgCtrl, 8'hFF);
        chk(safetyCheckCtrl, 8'h3C);
        stat2Events = 8'h81;
        stat4Events = 8'h42;
        deviceState = 3'h5;
        logicSelfTestDone = 1'b1;
        @(posedge clk) #1;
        logicSelfTestDone = 1'b0;
        stat2Events = 8'h00;
        stat4Events = 8'h00;
        chk(diagMuxSel | diagCfgCtrl | safetyCheckCtrl, 8'h00);
        frame(7'h62, 8'h00, 1'b0);
        chk(rx[7:0], 8'h81);
        frame(7'h52, 8'h00, 1'b0);
        chk(rx[7:0], 8'h42);
        frame(7'h60, 8'h00, 1'b0);
        chk(rx[7:0], 8'h05);
        chk(rx[7:0] & 8'h07, 8'h05);
    endtask
    initial
    begin
        #500us;
        bad_count++;
        final_report;
    end
    initial
    begin
        reset = 1'b1;
        diagState = 1'b0;
        deviceState = 3'h2;
        logicSelfTestDone = 1'b0;
        safetyStat1 = 8'h96;
        safetyStat3 = 8'h3C;
        stat2Events = 8'h00;
        stat4Events = 8'h00;
        sleepSeen = 1'b0;
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reads;
        t_writes;
        t_lock;
        t_error;
        t_reinit;
        final_report;
    end
endmodule
`default_nettype wire
